// ==== design/fdj_top.sv ====
// Overview of operation
// - Level one flag sets above its threshold
// - Level one clears below threshold minus hysteresis
// - Second level detector works the same way
// - Hysteresis only while frequency is falling
// - Two skip points; both zero disables skipping
// - Skipped band is twice the amplitude wide
// - Accelerating: dwell, then jump above band
// - Decelerating: dwell, then jump below band
// - Ramp skip disabled: hold current frequency
// - Ramp skip enabled: cross the whole band
// - Reverse inhibit blocks reverse running
// - Inhibit 0 allows reverse, 1 blocks; reset 0
// - Direction invert reverses commanded rotation
// - Invert 0 default direction, 1 opposite; reset 0
//
// Register access over APB and the register offsets were chosen for this implementation.
module fdj_top
  import fdj_pkg::*;
(
  // Clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // APB slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [AW-1:0] paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  // From the ramp generator
  input  wire logic [FW-1:0] ramp_freq,
  input  wire logic          reverse_request,
  // To motor control and output terminals
  output logic      [FW-1:0] drive_freq,
  output logic               drive_reverse,
  output logic               level_one_flag,
  output logic               level_two_flag,
  output logic               irq
);

  fdj_state_t s_reg;
  fdj_state_t s_next;

  // Hysteresis width in fixed point: threshold times tenths of a percent
  function automatic logic [FW-1:0] hyst_width(input logic [FW-1:0] thr, input logic [PW-1:0] pct);
    logic [FW+PW-1:0] prod;
    prod = thr * pct;
    return FW'(prod / (FW+PW)'(PCT_FULL));
  endfunction

  function automatic logic level_next(input logic cur, input logic [FW-1:0] f, input logic [FW-1:0] fprev,
                                      input logic [FW-1:0] thr, input logic [PW-1:0] pct);
    logic res;
    res = cur;
    if (f > thr) begin
      res = 1'b1;
    end else if (f < fprev) begin
      if (f < thr - hyst_width(thr, pct)) begin
        res = 1'b0;
      end
    end else if (f < thr) begin
      res = 1'b0;
    end
    return res;
  endfunction

  // A point of zero never matches, so each point switches off on its own
  function automatic logic in_band(input logic [FW-1:0] f, input logic [FW-1:0] sp, input logic [FW-1:0] amp);
    return (sp != '0) && ({1'b0, f} + {1'b0, amp} >= {1'b0, sp}) && ({1'b0, f} <= {1'b0, sp} + {1'b0, amp});
  endfunction

  function automatic logic [FW-1:0] clamp(input logic [31:0] v, input logic [FW-1:0] lim);
    return (v > {{(32-FW){1'b0}}, lim}) ? lim : v[FW-1:0];
  endfunction

  logic            hit1;
  logic            hit2;
  logic            hit;
  logic [FW-1:0]   sp;
  logic [FW:0]     band_hi;
  logic [FW-1:0]   band_lo;
  logic            rev_eff;
  logic            blocked;
  logic [FW-1:0]   drive_new;
  logic [IW-1:0]   ev;
  logic            access;
  logic            done;
  logic            mapped;
  logic [31:0]     rd;
  logic [31:0]     wv;

  always_comb begin
    s_next = s_reg;
    ev     = '0;
    wv     = pwdata;

    // Skip band around the first matching point
    hit1    = in_band(ramp_freq, s_reg.skip1, s_reg.amp);
    hit2    = in_band(ramp_freq, s_reg.skip2, s_reg.amp);
    hit     = hit1 | hit2;
    sp      = hit1 ? s_reg.skip1 : s_reg.skip2;
    band_hi = {1'b0, sp} + {1'b0, s_reg.amp};
    band_lo = (sp > s_reg.amp) ? sp - s_reg.amp : '0;

    s_next.ramp_prev = ramp_freq;
    unique case (s_reg.skip)
      SK_TRACK: begin
        if (!hit) begin
          s_next.shaped = ramp_freq;
        end else if (s_reg.ctrl[CTRL_SKIP_RAMP_EN]) begin
          // Approach from below means accelerating through the band
          s_next.skip   = SK_DWELL;
          s_next.cnt    = s_reg.dwell;
          s_next.target = (s_reg.shaped <= sp) ? clamp({{(31-FW){1'b0}}, band_hi}, s_reg.maxf)
                                               : band_lo;
        end
        // With ramp skip disabled the shaped value simply holds
      end
      SK_DWELL: begin
        if (!hit) begin
          s_next.skip   = SK_TRACK;
          s_next.shaped = ramp_freq;
        end else if (s_reg.cnt <= DW'(1)) begin
          s_next.skip   = SK_JUMPED;
          s_next.shaped = s_reg.target;
          ev[EV_JUMP]   = 1'b1;
        end else begin
          s_next.cnt = s_reg.cnt - DW'(1);
        end
      end
      SK_JUMPED: begin
        if (hit) begin
          s_next.shaped = s_reg.target;
        end else begin
          s_next.skip   = SK_TRACK;
          s_next.shaped = ramp_freq;
        end
      end
    endcase

    // Blocked reverse command runs at zero frequency
    blocked        = reverse_request & s_reg.ctrl[CTRL_REV_INHIBIT];
    rev_eff        = reverse_request & ~s_reg.ctrl[CTRL_REV_INHIBIT];
    drive_new      = blocked ? '0 : s_reg.shaped;
    s_next.rot_dir = rev_eff ^ s_reg.ctrl[CTRL_DIR_INVERT];
    s_next.rev_blk = blocked;
    ev[EV_REV_BLK] = blocked & ~s_reg.rev_blk;

    s_next.drive_freq = drive_new;
    s_next.freq_prev  = s_reg.drive_freq;
    s_next.lvl1 = level_next(s_reg.lvl1, s_reg.drive_freq, s_reg.freq_prev, s_reg.thr1, s_reg.pct1);
    s_next.lvl2 = level_next(s_reg.lvl2, s_reg.drive_freq, s_reg.freq_prev, s_reg.thr2, s_reg.pct2);
    ev[EV_L1_RISE] = s_next.lvl1 & ~s_reg.lvl1;
    ev[EV_L1_FALL] = ~s_next.lvl1 & s_reg.lvl1;
    ev[EV_L2_RISE] = s_next.lvl2 & ~s_reg.lvl2;
    ev[EV_L2_FALL] = ~s_next.lvl2 & s_reg.lvl2;

    // APB: one wait state so that read data comes from a flip-flop
    access = psel & penable;
    done   = access & s_reg.pready;
    mapped = 1'b1;
    rd     = '0;
    unique case (paddr)
      OFS_CTRL:     rd = {29'h0, s_reg.ctrl};
      OFS_LVL1_THR: rd = {16'h0, s_reg.thr1};
      OFS_LVL1_PCT: rd = {21'h0, s_reg.pct1};
      OFS_LVL2_THR: rd = {16'h0, s_reg.thr2};
      OFS_LVL2_PCT: rd = {21'h0, s_reg.pct2};
      OFS_SKIP1:    rd = {16'h0, s_reg.skip1};
      OFS_SKIP2:    rd = {16'h0, s_reg.skip2};
      OFS_SKIP_AMP: rd = {16'h0, s_reg.amp};
      OFS_DWELL:    rd = {16'h0, s_reg.dwell};
      OFS_STATUS:   rd = {26'h0, s_reg.skip, s_reg.rot_dir, s_reg.rev_blk, s_reg.lvl2, s_reg.lvl1};
      OFS_IRQ_STAT: rd = {26'h0, s_reg.irq_stat};
      OFS_IRQ_MASK: rd = {26'h0, s_reg.irq_mask};
      OFS_MAX_FREQ: rd = {16'h0, s_reg.maxf};
      OFS_RUN_FREQ: rd = {16'h0, s_reg.drive_freq};
      default:      mapped = 1'b0;
    endcase

    s_next.pready  = access & ~s_reg.pready;
    s_next.pslverr = access & ~s_reg.pready & ~mapped;
    if (access & ~s_reg.pready) begin
      s_next.prdata = pwrite ? 32'h0 : rd;
    end

    // Events always win over the read clear; only bits that were reported are cleared
    s_next.irq_stat = s_reg.irq_stat | ev;
    if (done & ~pwrite & (paddr == OFS_IRQ_STAT)) begin
      s_next.irq_stat = ev | (s_reg.irq_stat & ~s_reg.prdata[IW-1:0]);
    end

    // Thresholds beyond the maximum frequency are clamped on write
    if (done & pwrite) begin
      unique case (paddr)
        OFS_CTRL:     s_next.ctrl     = wv[2:0];
        OFS_LVL1_THR: s_next.thr1     = clamp(wv, s_reg.maxf);
        OFS_LVL1_PCT: s_next.pct1     = PW'(clamp(wv, FW'(PCT_FULL)));
        OFS_LVL2_THR: s_next.thr2     = clamp(wv, s_reg.maxf);
        OFS_LVL2_PCT: s_next.pct2     = PW'(clamp(wv, FW'(PCT_FULL)));
        OFS_SKIP1:    s_next.skip1    = clamp(wv, s_reg.maxf);
        OFS_SKIP2:    s_next.skip2    = clamp(wv, s_reg.maxf);
        OFS_SKIP_AMP: s_next.amp      = clamp(wv, AMP_MAX);
        OFS_DWELL:    s_next.dwell    = wv[DW-1:0];
        OFS_IRQ_MASK: s_next.irq_mask = wv[IW-1:0];
        OFS_MAX_FREQ: s_next.maxf     = wv[FW-1:0];
        default: begin
        end
      endcase
    end

    s_next.irq = |(s_next.irq_stat & s_next.irq_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= FDJ_STATE_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata         = s_reg.prdata;
  assign pready         = s_reg.pready;
  assign pslverr        = s_reg.pslverr;
  assign drive_freq     = s_reg.drive_freq;
  assign drive_reverse  = s_reg.rot_dir;
  assign level_one_flag = s_reg.lvl1;
  assign level_two_flag = s_reg.lvl2;
  assign irq            = s_reg.irq;

endmodule

// ==== design/fdj_pkg.sv ====
package fdj_pkg;

  // Widths: frequency in 0.01 Hz steps, percentage in 0.1 % steps
  localparam int FW = 16;
  localparam int PW = 11;
  localparam int DW = 16;
  localparam int IW = 6;
  localparam int AW = 8;

  // Register byte offsets
  localparam logic [AW-1:0] OFS_CTRL      = 8'h00;
  localparam logic [AW-1:0] OFS_LVL1_THR  = 8'h04;
  localparam logic [AW-1:0] OFS_LVL1_PCT  = 8'h08;
  localparam logic [AW-1:0] OFS_LVL2_THR  = 8'h0C;
  localparam logic [AW-1:0] OFS_LVL2_PCT  = 8'h10;
  localparam logic [AW-1:0] OFS_SKIP1     = 8'h14;
  localparam logic [AW-1:0] OFS_SKIP2     = 8'h18;
  localparam logic [AW-1:0] OFS_SKIP_AMP  = 8'h1C;
  localparam logic [AW-1:0] OFS_DWELL     = 8'h20;
  localparam logic [AW-1:0] OFS_STATUS    = 8'h24;
  localparam logic [AW-1:0] OFS_IRQ_STAT  = 8'h28;
  localparam logic [AW-1:0] OFS_IRQ_MASK  = 8'h2C;
  localparam logic [AW-1:0] OFS_MAX_FREQ  = 8'h30;
  localparam logic [AW-1:0] OFS_RUN_FREQ  = 8'h34;

  // Control register fields
  localparam int CTRL_SKIP_RAMP_EN = 0;
  localparam int CTRL_REV_INHIBIT  = 1;
  localparam int CTRL_DIR_INVERT   = 2;

  // Interrupt status fields
  localparam int EV_L1_RISE = 0;
  localparam int EV_L1_FALL = 1;
  localparam int EV_L2_RISE = 2;
  localparam int EV_L2_FALL = 3;
  localparam int EV_JUMP    = 4;
  localparam int EV_REV_BLK = 5;

  // Status register fields
  localparam int ST_LVL1    = 0;
  localparam int ST_LVL2    = 1;
  localparam int ST_REV_BLK = 2;
  localparam int ST_ROT     = 3;
  localparam int ST_SKIP    = 4;

  // Values after reset and limits
  localparam logic [FW-1:0] THR_RST      = 16'h1388;
  localparam logic [PW-1:0] PCT_RST      = 11'h032;
  localparam logic [PW-1:0] PCT_FULL     = 11'h3E8;
  localparam logic [FW-1:0] SKIP_RST     = 16'h0000;
  localparam logic [FW-1:0] AMP_RST      = 16'h0000;
  localparam logic [FW-1:0] AMP_MAX      = 16'h01F4;
  localparam logic [FW-1:0] MAX_FREQ_RST = 16'h1388;
  localparam logic [2:0]    CTRL_RST     = 3'h0;
  localparam logic [IW-1:0] IRQ_MASK_RST = 6'h00;

  // Dwell at a skip point, default time and its cycle count at the core clock
  localparam int CLK_HZ        = 10_000_000;
  localparam int DWELL_TIME_US = 100;
  localparam logic [DW-1:0] DWELL_RST = DW'(DWELL_TIME_US * (CLK_HZ / 1_000_000));

  typedef enum logic [1:0] {SK_TRACK, SK_DWELL, SK_JUMPED} fdj_skip_t;

  typedef struct packed {
    logic [2:0]    ctrl;
    logic [FW-1:0] thr1;
    logic [FW-1:0] thr2;
    logic [PW-1:0] pct1;
    logic [PW-1:0] pct2;
    logic [FW-1:0] skip1;
    logic [FW-1:0] skip2;
    logic [FW-1:0] amp;
    logic [FW-1:0] maxf;
    logic [DW-1:0] dwell;
    logic [IW-1:0] irq_stat;
    logic [IW-1:0] irq_mask;
    fdj_skip_t     skip;
    logic [DW-1:0] cnt;
    logic [FW-1:0] target;
    logic [FW-1:0] ramp_prev;
    logic [FW-1:0] shaped;
    logic [FW-1:0] drive_freq;
    logic [FW-1:0] freq_prev;
    logic          rot_dir;
    logic          rev_blk;
    logic          lvl1;
    logic          lvl2;
    logic          irq;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
  } fdj_state_t;

  localparam fdj_state_t FDJ_STATE_RST = '{
    ctrl:     CTRL_RST,
    thr1:     THR_RST,
    thr2:     THR_RST,
    pct1:     PCT_RST,
    pct2:     PCT_RST,
    skip1:    SKIP_RST,
    skip2:    SKIP_RST,
    amp:      AMP_RST,
    maxf:     MAX_FREQ_RST,
    dwell:    DWELL_RST,
    irq_mask: IRQ_MASK_RST,
    skip:     SK_TRACK,
    default:  '0
  };

endpackage

// ==== tb/fdj_assertions.sv ====
module fdj_assertions
  import fdj_pkg::*;
(
  // Clock, reset and APB
  input wire logic          pclk,
  input wire logic          presetn,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0]   pwdata,
  input wire logic [31:0]   prdata,
  input wire logic          pready,
  input wire logic          pslverr,
  // Drive path
  input wire logic [FW-1:0] ramp_freq,
  input wire logic          reverse_request,
  input wire logic [FW-1:0] drive_freq,
  input wire logic          drive_reverse,
  input wire logic          level_one_flag,
  input wire logic          level_two_flag,
  input wire logic          irq
);
  timeunit 1ns;
  timeprecision 1ns;

  // Shadow of the few settings the checks depend on, fed by completed writes
  logic [2:0] ctl_reg;
  logic [2:0] nz_reg;
  wire  logic wr = psel && penable && pready && pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_reg <= 3'h0;
      nz_reg  <= 3'h0;
    end else if (wr) begin
      if (paddr == OFS_CTRL) ctl_reg <= pwdata[2:0];
      if (paddr == OFS_SKIP1) nz_reg[0] <= |pwdata[FW-1:0];
      if (paddr == OFS_SKIP2) nz_reg[1] <= |pwdata[FW-1:0];
      if (paddr == OFS_IRQ_MASK) nz_reg[2] <= |pwdata[IW-1:0];
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_setup; psel && !penable; endsequence
  sequence s_rev_still; (!wr && $stable(reverse_request)) [*3]; endsequence
  sequence s_rev_blocked; (reverse_request && ctl_reg[1]) [*2]; endsequence

  property p_ready; s_setup |=> !pready ##1 pready; endproperty
  property p_pulse; pready |=> !pready; endproperty
  property p_err; pslverr |-> pready && psel && penable; endproperty
  property p_wzero; pready && pwrite |-> prdata == 32'h0; endproperty
  property p_inhibit; s_rev_blocked |-> drive_freq == 16'h0000; endproperty
  property p_dir; s_rev_still |-> drive_reverse == ((reverse_request && !ctl_reg[1]) ^ ctl_reg[2]); endproperty
  property p_follow;
    (!nz_reg[0] && !nz_reg[1] && !reverse_request) [*3] |-> drive_freq == $past(ramp_freq, 2);
  endproperty
  property p_irq; (!nz_reg[2]) [*2] |-> !irq; endproperty

  a_ready: assert property (p_ready) else $error("apb answer late");
  a_pulse: assert property (p_pulse) else $error("apb ready too long");
  a_err: assert property (p_err) else $error("stray slave error");
  a_wzero: assert property (p_wzero) else $error("write returned data");
  a_inhibit: assert property (p_inhibit) else $error("reverse not blocked");
  a_dir: assert property (p_dir) else $error("wrong direction");
  a_follow: assert property (p_follow) else $error("drive not following");
  a_irq: assert property (p_irq) else $error("masked irq raised");
endmodule

// ==== tb/fdj_ramp_model.sv ====
module fdj_ramp_model
  import fdj_pkg::*;
(
  // Clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // Speed command
  input  wire logic [FW-1:0] target,
  input  wire logic [FW-1:0] step,
  // Ramp output
  output logic      [FW-1:0] ramp_freq
);
  timeunit 1ns;
  timeprecision 1ns;

  // A large step models a fast ramp, a step of 1 a slow one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ramp_freq <= '0;
    else if (ramp_freq + step <= target) ramp_freq <= ramp_freq + step;
    else if (ramp_freq >= target + step) ramp_freq <= ramp_freq - step;
    else ramp_freq <= target;
  end
endmodule

// ==== tb/tb.sv ====
module tb
  import fdj_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic          pclk = 1'b0;
  logic          presetn = 1'b0;
  logic          psel = 1'b0;
  logic          penable = 1'b0;
  logic          pwrite = 1'b0;
  logic [AW-1:0] paddr = '0;
  logic [31:0]   pwdata = '0;
  logic          reverse_request = 1'b0;
  logic [FW-1:0] target = '0;
  logic [FW-1:0] step = 16'h0001;
  logic [31:0]   prdata;
  logic          pready, pslverr, drive_reverse, level_one_flag, level_two_flag, irq;
  logic [FW-1:0] ramp_freq, drive_freq, ef;
  logic [FW-1:0] e1 = '0;
  logic [FW-1:0] rq[$] = '{16'h0000, 16'h0000};
  logic          mon = 1'b0, sk = 1'b0, m1 = 1'b0, m2 = 1'b0, up_seen = 1'b0, dn_seen = 1'b0;
  int            bad_count = 0, n_tests = 0, t1 = 5000, p1 = 50, t2 = 5000, p2 = 50;

  always #50 pclk = ~pclk;

  fdj_top fdj_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ramp_freq(ramp_freq), .reverse_request(reverse_request), .drive_freq(drive_freq),
    .drive_reverse(drive_reverse), .level_one_flag(level_one_flag), .level_two_flag(level_two_flag), .irq(irq));
  fdj_ramp_model fdj_ramp_model_inst (.pclk(pclk), .presetn(presetn), .target(target), .step(step),
    .ramp_freq(ramp_freq));

  task chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task apb(input logic w, input logic [AW-1:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Request stands until the edge that samples ready; data is taken at that edge
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [AW-1:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task ramp_to(input logic [FW-1:0] t, input logic [FW-1:0] s);
    @(posedge pclk);
    target <= t;
    step <= s;
    do @(posedge pclk); while (ramp_freq !== t);
    repeat (4) @(posedge pclk);
  endtask

  function automatic logic lvl(input logic [FW-1:0] f, input logic [FW-1:0] fp, input logic fl,
                               input int thr, input int pct);
    if (f > thr) return 1'b1;
    if (f < fp) return (f < thr - thr * pct / 1000) ? 1'b0 : fl;
    return (f < thr) ? 1'b0 : fl;
  endfunction

  always @(negedge pclk) begin
    if (mon) begin
      rq.push_back(ramp_freq);
      ef = rq[rq.size() - 3];
      chk(drive_freq, ef);
      chk(level_one_flag, m1);
      chk(level_two_flag, m2);
      m1 = lvl(ef, e1, m1, t1, p1);
      m2 = lvl(ef, e1, m2, t2, p2);
      e1 = ef;
    end
    if (sk && drive_freq > 16'h079C && drive_freq < 16'h0864) chk(drive_freq, 16'h0864);
    if (sk && drive_freq == 16'h0864) up_seen = 1'b1;
    if (sk && drive_freq == 16'h079C) dn_seen = 1'b1;
  end

  task final_report;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  localparam logic [AW-1:0] RA [9] = '{OFS_CTRL, OFS_LVL1_THR, OFS_LVL1_PCT, OFS_LVL2_THR, OFS_LVL2_PCT,
                                       OFS_SKIP1, OFS_SKIP_AMP, OFS_DWELL, OFS_MAX_FREQ};
  localparam logic [31:0]   RV [9] = '{32'h0, 32'h1388, 32'h32, 32'h1388, 32'h32, 32'h0, 32'h0, 32'h3E8, 32'h1388};
  localparam logic [FW-1:0] TG [7] = '{16'h1000, 16'h0EDC, 16'h0FA0, 16'h0700, 16'h0F00, 16'h0730, 16'h0000};

  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    final_report;
  end

  initial begin
    logic [31:0] r;
    logic        e;
    r = $urandom(32'hA7907B17);
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    mon <= 1'b1;
    foreach (RA[i]) begin
      apb(1'b0, RA[i], 32'h0, r, e);
      chk(r, RV[i]);
    end
    apb(1'b0, 8'h40, 32'h0, r, e);
    chk(r, 32'h0);
    chk({31'h0, e}, 32'h1);
    $display("register test done");
    wr(OFS_LVL1_THR, 32'h07D0);
    wr(OFS_LVL1_PCT, 32'h64);
    wr(OFS_LVL2_THR, 32'h0FA0);
    {t1, p1, t2} = {32'd2000, 32'd100, 32'd4000};
    foreach (TG[i]) ramp_to(TG[i], FW'($urandom_range(64, 16)));
    mon <= 1'b0;
    $display("level test done");
    wr(OFS_SKIP1, 32'h0800);
    wr(OFS_SKIP_AMP, 32'h64);
    wr(OFS_DWELL, 32'h4);
    wr(OFS_IRQ_MASK, 32'h10);
    wr(OFS_CTRL, 32'h1);
    sk <= 1'b1;
    ramp_to(16'h0A00, 16'h0008);
    @(negedge pclk);
    chk({irq, up_seen}, 2'h3);
    apb(1'b0, OFS_IRQ_STAT, 32'h0, r, e);
    chk(r[EV_JUMP], 1'b1);
    repeat (2) @(negedge pclk);
    chk(irq, 1'b0);
    ramp_to(16'h0000, 16'h0008);
    chk(dn_seen, 1'b1);
    wr(OFS_CTRL, 32'h0);
    ramp_to(16'h0800, 16'h0008);
    @(negedge pclk);
    chk(drive_freq < 16'h079C, 1'b1);
    ramp_to(16'h0000, 16'h0008);
    sk <= 1'b0;
    $display("skip test done");
    ramp_to(16'h0400, 16'h0010);
    for (int i = 0; i < 8; i++) begin
      wr(OFS_CTRL, {29'h0, i[1:0], 1'b0});
      reverse_request <= i[2];
      repeat (4) @(negedge pclk);
      chk(drive_reverse, (i[2] & ~i[0]) ^ i[1]);
      if (i[2] & i[0]) chk(drive_freq, 16'h0000);
    end
    $display("direction test done");
    final_report;
  end
endmodule

bind fdj_top fdj_assertions fdj_assertions_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ramp_freq(ramp_freq), .reverse_request(reverse_request), .drive_freq(drive_freq),
  .drive_reverse(drive_reverse), .level_one_flag(level_one_flag), .level_two_flag(level_two_flag), .irq(irq));
